// *** vrc_pkg.sv ***
// package for the voltage reference control block: register map, fields, carriers
package vrc_pkg;
    // register map (one aligned word per register, byte addresses)
    localparam logic [3:0] VRC_CTRL_OFS      = 4'h0;  // voltage_reference_control
    localparam logic [3:0] VRC_STATUS_OFS    = 4'h4;  // registered ladder ratio numerator/denominator, read only
    localparam logic [3:0] VRC_PORTDIR_OFS   = 4'h8;  // port_f_direction bit 5 mirror, read only
    localparam logic [7:0] VRC_CTRL_RESET    = 8'h00;
    localparam logic [31:0] VRC_UNMAPPED_RD  = 32'h00000000;
    // field positions inside the control register
    localparam int VRC_EN_BIT    = 7;
    localparam int VRC_OE_BIT    = 6;
    localparam int VRC_RANGE_BIT = 5;
    localparam int VRC_SRC_BIT   = 4;
    localparam int VRC_TAP_MSB   = 3;
    localparam int VRC_TAP_LSB   = 0;
    localparam int VRC_PIN5_IDX  = 5;    // pin of port f carrying the reference
    // ladder divisors per range
    localparam logic [5:0] VRC_DIV_LOW_RANGE  = 6'h18; // range 1: tap/24
    localparam logic [5:0] VRC_DIV_HIGH_RANGE = 6'h20; // range 0: 1/4 + tap/32
    localparam logic [5:0] VRC_HIGH_OFFSET    = 6'h08; // quarter of supply in 32nds

    // range select encodings
    typedef enum logic {
        VRC_RANGE_HIGH = 1'b0,
        VRC_RANGE_LOW  = 1'b1
    } vrc_range_t;

    // source select encodings
    typedef enum logic {
        VRC_SRC_RAILS    = 1'b0,
        VRC_SRC_EXTERNAL = 1'b1
    } vrc_source_t;

    // analog ladder controls
    typedef struct packed {
        logic        reference_enable;
        vrc_range_t  reference_range_select;
        vrc_source_t reference_source_select;
        logic [3:0]  reference_tap_select;
    } vrc_ladder_t;

    // ladder ratio numerator/denominator for the selected level
    typedef struct packed {
        logic [5:0] numerator;
        logic [5:0] denominator;
    } vrc_ratio_t;
endpackage : vrc_pkg

// *** vrc_ctrl.sv ***
// voltage reference control register with avalon-mm slave and pin gating
//
// Chosen here: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module vrc_ctrl (
    // clock and reset
    input  wire logic                clock,
    input  wire logic                nrst,
    // avalon-mm slave
    input  wire logic [3:0]          address,
    input  wire logic                read,
    input  wire logic                write,
    input  wire logic [31:0]         writedata,
    input  wire logic [3:0]          byteenable,
    output logic      [31:0]         readdata,
    output logic                     waitrequest,
    // sleep and port context
    input  wire logic                sleep_wake,
    input  wire logic                port_f_direction,
    // analog ladder
    output vrc_pkg::vrc_ladder_t     ladder_ctrl,
    output vrc_pkg::vrc_ratio_t      ladder_ratio,
    output logic                     reference_output_to_pin,
    output logic                     port_f_pin5_analog_sel
);
    import vrc_pkg::*;

    logic [7:0]  ctrl_ff;
    logic [31:0] readdata_ff;
    logic        rd_done_ff;
    logic        wr_hit;
    logic        rd_req;
    vrc_ratio_t  nxt_ratio;
    vrc_ratio_t  ratio_ff;
    logic        nxt_pin;
    logic        pin_ff;

    // ratio of supply for the chosen range and tap
    function automatic vrc_ratio_t level_ratio(input logic range_bit, input logic [3:0] tap);
        vrc_ratio_t r;
        if (range_bit) begin
            r.numerator   = {2'h0, tap};
            r.denominator = VRC_DIV_LOW_RANGE;
        end else begin
            r.numerator   = VRC_HIGH_OFFSET + {2'h0, tap};
            r.denominator = VRC_DIV_HIGH_RANGE;
        end
        return r;
    endfunction : level_ratio

    // writes complete at once; reads take one extra cycle to register data
    assign wr_hit      = write && (address == VRC_CTRL_OFS) && byteenable[0];
    assign rd_req      = read && !write;
    assign waitrequest = rd_req && !rd_done_ff;

    // control register; sleep_wake has no path here so wake keeps the contents
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ctrl_ff <= VRC_CTRL_RESET;
        end else if (wr_hit) begin
            ctrl_ff <= writedata[7:0];
        end
    end

    // registered read data, no side effects on any read
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            readdata_ff <= VRC_UNMAPPED_RD;
            rd_done_ff  <= 1'b0;
        end else begin
            rd_done_ff <= rd_req && !rd_done_ff;
            if (rd_req && !rd_done_ff) begin
                case (address)
                    VRC_CTRL_OFS:    readdata_ff <= {24'h0, ctrl_ff};
                    VRC_STATUS_OFS:  readdata_ff <= {20'h0, ratio_ff};
                    VRC_PORTDIR_OFS: readdata_ff <= {30'h0, pin_ff, port_f_direction};
                    default:         readdata_ff <= VRC_UNMAPPED_RD;
                endcase
            end
        end
    end
    assign readdata = readdata_ff;

    // ladder controls straight from the register, no comparator input exists
    assign ladder_ctrl.reference_enable        = ctrl_ff[VRC_EN_BIT];
    assign ladder_ctrl.reference_range_select  = vrc_range_t'(ctrl_ff[VRC_RANGE_BIT]);
    assign ladder_ctrl.reference_source_select = vrc_source_t'(ctrl_ff[VRC_SRC_BIT]);
    assign ladder_ctrl.reference_tap_select    = ctrl_ff[VRC_TAP_MSB:VRC_TAP_LSB];

    // ratio registered so the data output comes from flip-flops
    assign nxt_ratio = level_ratio(ctrl_ff[VRC_RANGE_BIT], ctrl_ff[VRC_TAP_MSB:VRC_TAP_LSB]);
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            ratio_ff <= '0;
        end else begin
            ratio_ff <= nxt_ratio;
        end
    end
    assign ladder_ratio = ratio_ff;

    // pin gating; also needs the pin's direction bit, so a one-cycle lag
    assign nxt_pin = ctrl_ff[VRC_OE_BIT] && port_f_direction;
    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end
    assign reference_output_to_pin = pin_ff;
    assign port_f_pin5_analog_sel  = pin_ff;

    // assertions: state of the register, the pin drive and the ladder controls right after reset
    reset_clears_a: assert property (@(posedge clock) $rose(nrst) |-> ctrl_ff == VRC_CTRL_RESET)
        else $error("control not cleared by reset");
    reset_pin_off_a: assert property (@(posedge clock) $rose(nrst) |-> !reference_output_to_pin)
        else $error("pin drive not cleared by reset");
    reset_ladder_off_a: assert property (@(posedge clock)
        $rose(nrst) |-> !ladder_ctrl.reference_enable && ladder_ctrl.reference_tap_select == 4'h0)
        else $error("ladder not powered down by reset");
    high_range_reset_a: assert property (@(posedge clock) disable iff (!nrst)
        $rose(nrst) |-> ladder_ctrl.reference_range_select == VRC_RANGE_HIGH)
        else $error("range not high after reset");

    // pin gating lags its two enables by one cycle, in both directions
    pin_gate_a: assert property (@(posedge clock) disable iff (!nrst)
        reference_output_to_pin |-> $past(ctrl_ff[VRC_OE_BIT]) && $past(port_f_direction))
        else $error("pin driven without both enables");
    pin_follow_a: assert property (@(posedge clock) disable iff (!nrst)
        ctrl_ff[VRC_OE_BIT] && port_f_direction |=> reference_output_to_pin)
        else $error("pin not driven with both enables");
    pin_dir_off_a: assert property (@(posedge clock) disable iff (!nrst)
        !port_f_direction |=> !reference_output_to_pin)
        else $error("pin driven while direction bit clear");

    // wake from sleep must not disturb the register
    wake_keeps_a: assert property (@(posedge clock) disable iff (!nrst)
        sleep_wake && !wr_hit |=> $stable(ctrl_ff))
        else $error("wake changed control");

    // ladder controls come only from the register fields
    ladder_only_a: assert property (@(posedge clock) disable iff (!nrst)
        ladder_ctrl.reference_tap_select == ctrl_ff[VRC_TAP_MSB:VRC_TAP_LSB]
        && ladder_ctrl.reference_enable == ctrl_ff[VRC_EN_BIT])
        else $error("ladder outputs not from register");
    source_sel_a: assert property (@(posedge clock) disable iff (!nrst)
        ladder_ctrl.reference_source_select == vrc_source_t'(ctrl_ff[VRC_SRC_BIT]))
        else $error("source select mismatch");

    // ratio follows the register one cycle later; the guard skips the reset value of the flop
    ratio_range_a: assert property (@(posedge clock) disable iff (!nrst)
        $past(nrst) |-> ladder_ratio.denominator
        == ($past(ctrl_ff[VRC_RANGE_BIT]) ? VRC_DIV_LOW_RANGE : VRC_DIV_HIGH_RANGE))
        else $error("ratio denominator wrong");
    ratio_num_a: assert property (@(posedge clock) disable iff (!nrst)
        $past(nrst) |-> ladder_ratio.numerator == ($past(ctrl_ff[VRC_RANGE_BIT])
        ? {2'h0, $past(ctrl_ff[VRC_TAP_MSB:VRC_TAP_LSB])}
        : VRC_HIGH_OFFSET + {2'h0, $past(ctrl_ff[VRC_TAP_MSB:VRC_TAP_LSB])}))
        else $error("ratio numerator wrong");

    // register bus: capture, refusal, wait states and read side effects
    write_capture_a: assert property (@(posedge clock) disable iff (!nrst)
        wr_hit |=> ctrl_ff == $past(writedata[7:0]))
        else $error("write not captured");
    write_no_wait_a: assert property (@(posedge clock) disable iff (!nrst)
        write |-> !waitrequest)
        else $error("write stalled");
    refused_write_a: assert property (@(posedge clock) disable iff (!nrst)
        write && (address != VRC_CTRL_OFS || !byteenable[0]) |=> $stable(ctrl_ff))
        else $error("refused write changed control");
    read_one_wait_a: assert property (@(posedge clock) disable iff (!nrst)
        waitrequest |=> !waitrequest)
        else $error("read stalled more than one cycle");
    read_no_side_a: assert property (@(posedge clock) disable iff (!nrst)
        read && !write |=> $stable(ctrl_ff))
        else $error("read changed control");
    read_value_a: assert property (@(posedge clock) disable iff (!nrst)
        read && address == VRC_CTRL_OFS && !waitrequest |-> readdata == {24'h0, ctrl_ff})
        else $error("read value wrong");
    readdata_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        !read |=> $stable(readdata))
        else $error("read data moved without a read");

    // main scenarios
    cov_write_c: cover property (@(posedge clock) disable iff (!nrst) wr_hit);
    cov_pin_c: cover property (@(posedge clock) disable iff (!nrst) $rose(reference_output_to_pin));
    cov_wake_c: cover property (@(posedge clock) disable iff (!nrst) sleep_wake && ctrl_ff[VRC_EN_BIT]);
    cov_high_pin_c: cover property (@(posedge clock) disable iff (!nrst)
        reference_output_to_pin && ladder_ctrl.reference_range_select == VRC_RANGE_HIGH);
    cov_midreset_c: cover property (@(posedge clock) $rose(nrst) && $past(ctrl_ff != VRC_CTRL_RESET, 3));
endmodule : vrc_ctrl

// *** vrc_ladder_model.sv ***
// behavioural analog ladder and pin mux, level reported in 96ths of supply
`timescale 1ns/1ps
module vrc_ladder_model (
    // ladder controls and pin drive
    input  wire vrc_pkg::vrc_ladder_t ladder_ctrl,
    input  wire logic                 pin_drive,
    // level seen on the pin
    output logic [7:0]                level_96
);
    import vrc_pkg::*;

    // 96 is the common multiple of 24 and 32; an undriven pin reads as ground here
    always_comb begin
        if (!pin_drive || !ladder_ctrl.reference_enable) begin
            level_96 = 8'h00;
        end else if (ladder_ctrl.reference_range_select == VRC_RANGE_LOW) begin
            level_96 = {4'h0, ladder_ctrl.reference_tap_select} * 8'h04;
        end else begin
            level_96 = 8'h18 + {4'h0, ladder_ctrl.reference_tap_select} * 8'h03;
        end
    end
endmodule : vrc_ladder_model

// *** vrc_ctrl_bench.sv ***
// self-checking bench for the voltage reference control block
`timescale 1ns/1ps
module vrc_ctrl_bench;
    import vrc_pkg::*;
    logic        clock = 1'b0, nrst = 1'b0, read = 1'b0, write = 1'b0;
    logic        sleep_wake = 1'b0, port_f_direction = 1'b0, waitrequest, pin, asel;
    logic [3:0]  address = 4'h0, byteenable = 4'hF;
    logic [31:0] writedata = 32'h0, readdata, rd;
    logic [7:0]  level_96;
    vrc_ladder_t ladder_ctrl;
    vrc_ratio_t  ladder_ratio;
    int          failures = 0, checks = 0;
    // 40 MHz clock
    always #12.5 clock = ~clock;
    vrc_ctrl u_vrc_ctrl (.clock(clock), .nrst(nrst), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest),
        .sleep_wake(sleep_wake), .port_f_direction(port_f_direction), .ladder_ctrl(ladder_ctrl),
        .ladder_ratio(ladder_ratio), .reference_output_to_pin(pin), .port_f_pin5_analog_sel(asel));
    vrc_ladder_model u_vrc_ladder_model (.ladder_ctrl(ladder_ctrl), .pin_drive(pin), .level_96(level_96));
    task automatic print_verdict;
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // one avalon transfer; waitrequest and read data are taken at the rising edge,
    // before that edge's updates land, since every input moves by non-blocking assignment
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clock);
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do begin
            @(posedge clock);
            n++;
            if (n > 20) begin
                failures++;
                print_verdict();
            end
        end while (waitrequest !== 1'b0);
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
    endtask : bus
    // pin and ratio outputs lag the register by one cycle; ends on a rising edge
    task automatic settle;
        repeat (2) @(posedge clock);
    endtask : settle
    task automatic t_reset;
        bus(1'b0, VRC_CTRL_OFS, 32'h0);
        chk(rd, 32'h0);
        chk({25'h0, ladder_ctrl}, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_rw;
        logic [7:0] p [4] = '{8'hFF, 8'hA5, 8'h5A, 8'h00};
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, VRC_CTRL_OFS, {24'h0, p[i]});
            bus(1'b0, VRC_CTRL_OFS, 32'h0);
            chk(rd, {24'h0, p[i]});
            chk({25'h0, ladder_ctrl}, {25'h0, p[i][7], p[i][5:0]});
            bus(1'b0, VRC_CTRL_OFS, 32'h0);
            chk(rd, {24'h0, p[i]});
        end
        $display("test read write done");
    endtask : t_rw
    task automatic t_ratio;
        bus(1'b1, VRC_CTRL_OFS, 32'hAF);
        settle();
        chk({20'h0, ladder_ratio}, {20'h0, 6'd15, 6'd24});
        bus(1'b1, VRC_CTRL_OFS, 32'h83);
        bus(1'b0, VRC_STATUS_OFS, 32'h0);
        chk(rd, {20'h0, 6'd11, 6'd32});
        $display("test ratio done");
    endtask : t_ratio
    task automatic t_pin;
        bus(1'b1, VRC_CTRL_OFS, 32'hE5);
        settle();
        chk({30'h0, pin, asel}, 32'h0);
        port_f_direction <= 1'b1;
        settle();
        chk({30'h0, pin, asel}, 32'h3);
        chk({24'h0, level_96}, 32'h14);
        bus(1'b0, VRC_PORTDIR_OFS, 32'h0);
        chk(rd, 32'h3);
        bus(1'b1, VRC_CTRL_OFS, 32'hC5);
        settle();
        chk({24'h0, level_96}, 32'h27);
        chk({20'h0, ladder_ratio}, {20'h0, 6'd13, 6'd32});
        bus(1'b1, VRC_CTRL_OFS, 32'hA5);
        settle();
        chk({31'h0, pin}, 32'h0);
        $display("test pin done");
    endtask : t_pin
    task automatic t_sleep_refuse;
        bus(1'b1, VRC_CTRL_OFS, 32'hB7);
        sleep_wake <= 1'b1;
        settle();
        sleep_wake <= 1'b0;
        bus(1'b0, VRC_CTRL_OFS, 32'h0);
        chk(rd, 32'hB7);
        byteenable <= 4'h0;
        bus(1'b1, VRC_CTRL_OFS, 32'h11);
        byteenable <= 4'hF;
        bus(1'b1, VRC_STATUS_OFS, 32'h22);
        bus(1'b0, VRC_CTRL_OFS, 32'h0);
        chk(rd, 32'hB7);
        bus(1'b0, 4'hC, 32'h0);
        chk(rd, VRC_UNMAPPED_RD);
        // software clears the enable before sleep, keeping the pin output on
        bus(1'b1, VRC_CTRL_OFS, 32'h57);
        sleep_wake <= 1'b1;
        settle();
        sleep_wake <= 1'b0;
        bus(1'b0, VRC_CTRL_OFS, 32'h0);
        chk(rd, 32'h57);
        chk({30'h0, pin, asel}, 32'h3);
        $display("test sleep and refusal done");
    endtask : t_sleep_refuse
    task automatic t_midreset;
        nrst <= 1'b0;
        settle();
        chk({25'h0, ladder_ctrl}, 32'h0);
        chk({30'h0, pin, asel}, 32'h0);
        nrst <= 1'b1;
        t_reset();
        settle();
        chk({20'h0, ladder_ratio}, {20'h0, 6'd8, 6'd32});
    endtask : t_midreset
    initial begin
        repeat (6) @(posedge clock);
        nrst <= 1'b1;
        t_reset();
        t_rw();
        t_ratio();
        t_pin();
        t_sleep_refuse();
        t_midreset();
        print_verdict();
    end
endmodule : vrc_ctrl_bench
